//--- include/fsa_pkg.sv
// Constants and code types for the four-bit slice with register stack.
// Assumes a single system clock that serves as the slice clock.
package fsa_pkg;

  localparam int unsigned FSA_WIDTH   = 4;   // Data path width of one slice
  localparam int unsigned FSA_DEPTH   = 16;  // Words in the register stack
  localparam int unsigned FSA_ADDR_W  = 4;   // Stack address width
  localparam int unsigned FSA_CODE_W  = 9;   // Microcode word width
  localparam int unsigned FSA_FIELD_W = 3;   // Width of each microcode field
  localparam int unsigned FSA_SRC_LSB  = 0;  // Operand-pair field position
  localparam int unsigned FSA_FUNC_LSB = 3;  // Function field position
  localparam int unsigned FSA_DEST_LSB = 6;  // Destination field position
  localparam int unsigned FSA_MSB     = 3;   // Most significant bit index
  localparam int unsigned FSA_LO_W    = 3;   // Bits below the MSB

  localparam logic [3:0] FSA_ZERO = 4'h0;    // Inhibited operand value

  // Operand pair select, first operand then second operand
  typedef enum logic [2:0] {
    FSA_SRC_AQ = 3'b000,
    FSA_SRC_AB = 3'b001,
    FSA_SRC_ZQ = 3'b010,
    FSA_SRC_ZB = 3'b011,
    FSA_SRC_ZA = 3'b100,
    FSA_SRC_DA = 3'b101,
    FSA_SRC_DQ = 3'b110,
    FSA_SRC_DZ = 3'b111
  } fsa_src_t;

  // Function select
  typedef enum logic [2:0] {
    FSA_FN_ADD  = 3'b000,
    FSA_FN_SUBR = 3'b001,
    FSA_FN_SUBS = 3'b010,
    FSA_FN_OR   = 3'b011,
    FSA_FN_AND  = 3'b100,
    FSA_FN_NAND = 3'b101,
    FSA_FN_XOR  = 3'b110,
    FSA_FN_XNOR = 3'b111
  } fsa_func_t;

  // Destination select
  typedef enum logic [2:0] {
    FSA_DST_QREG = 3'b000,
    FSA_DST_NOP  = 3'b001,
    FSA_DST_RAMA = 3'b010,
    FSA_DST_RAMF = 3'b011,
    FSA_DST_RQD  = 3'b100,
    FSA_DST_RD   = 3'b101,
    FSA_DST_RQU  = 3'b110,
    FSA_DST_RU   = 3'b111
  } fsa_dest_t;

  // All storage of the slice
  typedef struct packed {
    logic [FSA_DEPTH-1:0][FSA_WIDTH-1:0] stack;
    logic [FSA_WIDTH-1:0]                acc;
  } fsa_state_t;

endpackage

//--- core/fsa_slice.sv
// Four-bit processor slice: register stack, working register, ALU, shifters.
// Assumes the microcode word, addresses and direct input come from a pipeline
// register on sys_clk, and that neighbour slices share the same clock.

//////////////////////////////////////////////////////////////////////////////

module fsa_slice (
  input  wire logic                      sys_clk,               // Slice clock
  input  wire logic                      sys_rst,               // Unused by storage
  input  wire logic [8:0]                microcode_word,        // Operation word
  input  wire logic [3:0]                first_read_select,     // Port A address
  input  wire logic [3:0]                write_port_select,     // Port B address
  input  wire logic [3:0]                direct_input,          // External data
  input  wire logic                      carry_in,              // Carry in, high
  input  wire logic                      output_enable_n,       // Output enable, low
  output logic [3:0]                     slice_output_o,        // Result bus value
  output logic                           slice_output_oe,       // Result bus drive
  output logic                           carry_out,             // Carry out, high
  output logic                           signed_overflow,       // Overflow flag
  output logic                           carry_generate_n,      // Generate, low
  output logic                           carry_propagate_n,     // Propagate, low
  output logic                           result_msb,            // Result sign bit
  output logic                           zero_detect_o,         // Zero pin value
  output logic                           zero_detect_oe,        // Zero pin drive
  input  wire logic                      stack_msb_shift_pin_i, // Stack MSB pin in
  output logic                           stack_msb_shift_pin_o, // Stack MSB pin out
  output logic                           stack_msb_shift_pin_oe,// Stack MSB pin drive
  input  wire logic                      stack_lsb_shift_pin_i, // Stack LSB pin in
  output logic                           stack_lsb_shift_pin_o, // Stack LSB pin out
  output logic                           stack_lsb_shift_pin_oe,// Stack LSB pin drive
  input  wire logic                      acc_msb_shift_pin_i,   // Working MSB pin in
  output logic                           acc_msb_shift_pin_o,   // Working MSB pin out
  output logic                           acc_msb_shift_pin_oe,  // Working MSB pin drive
  input  wire logic                      acc_lsb_shift_pin_i,   // Working LSB pin in
  output logic                           acc_lsb_shift_pin_o,   // Working LSB pin out
  output logic                           acc_lsb_shift_pin_oe   // Working LSB pin drive
);

  //////////////////////////////////////////////////////////////////////////////

  fsa_pkg::fsa_state_t state_q;
  fsa_pkg::fsa_state_t state_d;
  fsa_pkg::fsa_src_t   src;
  fsa_pkg::fsa_func_t  func;
  fsa_pkg::fsa_dest_t  dest;
  logic [3:0]          port_a;
  logic [3:0]          port_b;
  logic [3:0]          op_r;
  logic [3:0]          op_s;
  logic [3:0]          r_eff;
  logic [3:0]          s_eff;
  logic [3:0]          gen;
  logic [3:0]          prop;
  logic [3:0]          low_sum;
  logic [4:0]          full_sum;
  logic [3:0]          alu_f;
  logic                arith;
  logic                c_msb_in;
  logic                c_msb_out;

  //////////////////////////////////////////////////////////////////////////////
  // Datapath and next state

  always_comb begin
    state_d = state_q;
    src  = fsa_pkg::fsa_src_t'(microcode_word[fsa_pkg::FSA_SRC_LSB +: fsa_pkg::FSA_FIELD_W]);
    func = fsa_pkg::fsa_func_t'(microcode_word[fsa_pkg::FSA_FUNC_LSB +: fsa_pkg::FSA_FIELD_W]);
    dest = fsa_pkg::fsa_dest_t'(microcode_word[fsa_pkg::FSA_DEST_LSB +: fsa_pkg::FSA_FIELD_W]);
    // Reads see the stored words; a write lands only at the edge
    port_a = state_q.stack[first_read_select];
    port_b = state_q.stack[write_port_select];

    // Operand pairs, zero choice is the inhibit
    case (src)
      fsa_pkg::FSA_SRC_AQ: begin
        op_r = port_a;
        op_s = state_q.acc;
      end
      fsa_pkg::FSA_SRC_AB: begin
        op_r = port_a;
        op_s = port_b;
      end
      fsa_pkg::FSA_SRC_ZQ: begin
        op_r = fsa_pkg::FSA_ZERO;
        op_s = state_q.acc;
      end
      fsa_pkg::FSA_SRC_ZB: begin
        op_r = fsa_pkg::FSA_ZERO;
        op_s = port_b;
      end
      fsa_pkg::FSA_SRC_ZA: begin
        op_r = fsa_pkg::FSA_ZERO;
        op_s = port_a;
      end
      fsa_pkg::FSA_SRC_DA: begin
        op_r = direct_input;
        op_s = port_a;
      end
      fsa_pkg::FSA_SRC_DQ: begin
        op_r = direct_input;
        op_s = state_q.acc;
      end
      default: begin
        op_r = direct_input;
        op_s = fsa_pkg::FSA_ZERO;
      end
    endcase

    // Subtraction is an add of the complement plus carry in
    case (func)
      fsa_pkg::FSA_FN_SUBR: begin
        r_eff = ~op_r;
        s_eff = op_s;
      end
      fsa_pkg::FSA_FN_SUBS: begin
        r_eff = op_r;
        s_eff = ~op_s;
      end
      default: begin
        r_eff = op_r;
        s_eff = op_s;
      end
    endcase
    arith    = (func == fsa_pkg::FSA_FN_ADD) || (func == fsa_pkg::FSA_FN_SUBR) ||
               (func == fsa_pkg::FSA_FN_SUBS);
    low_sum  = {1'b0, r_eff[2:0]} + {1'b0, s_eff[2:0]} + {3'h0, carry_in};
    full_sum = {1'b0, r_eff} + {1'b0, s_eff} + {4'h0, carry_in};
    gen      = r_eff & s_eff;
    prop     = r_eff | s_eff;

    case (func)
      fsa_pkg::FSA_FN_OR:   alu_f = op_r | op_s;
      fsa_pkg::FSA_FN_AND:  alu_f = op_r & op_s;
      fsa_pkg::FSA_FN_NAND: alu_f = ~op_r & op_s;
      fsa_pkg::FSA_FN_XOR:  alu_f = op_r ^ op_s;
      fsa_pkg::FSA_FN_XNOR: alu_f = ~(op_r ^ op_s);
      default:              alu_f = full_sum[3:0];
    endcase
    // Logic functions report no carry so flags stay quiet
    c_msb_in  = arith & low_sum[fsa_pkg::FSA_LO_W];
    c_msb_out = arith & full_sum[fsa_pkg::FSA_WIDTH];

    // Loads and shifts, stored at the rising edge
    case (dest)
      fsa_pkg::FSA_DST_QREG: state_d.acc = alu_f;
      fsa_pkg::FSA_DST_RAMA,
      fsa_pkg::FSA_DST_RAMF: state_d.stack[write_port_select] = alu_f;
      fsa_pkg::FSA_DST_RQD: begin
        state_d.stack[write_port_select] = {stack_msb_shift_pin_i, alu_f[3:1]};
        state_d.acc = {acc_msb_shift_pin_i, state_q.acc[3:1]};
      end
      fsa_pkg::FSA_DST_RD:
        state_d.stack[write_port_select] = {stack_msb_shift_pin_i, alu_f[3:1]};
      fsa_pkg::FSA_DST_RQU: begin
        state_d.stack[write_port_select] = {alu_f[2:0], stack_lsb_shift_pin_i};
        state_d.acc = {state_q.acc[2:0], acc_lsb_shift_pin_i};
      end
      fsa_pkg::FSA_DST_RU:
        state_d.stack[write_port_select] = {alu_f[2:0], stack_lsb_shift_pin_i};
      default: ;
    endcase
  end

  // No reset: contents stay unknown until microcode writes them
  always_ff @(posedge sys_clk) begin
    state_q <= state_d;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs; combinational so carries and shifts ripple within one cycle

  assign slice_output_o  = (dest == fsa_pkg::FSA_DST_RAMA) ? port_a : alu_f;
  assign slice_output_oe = ~output_enable_n;
  assign carry_out       = c_msb_out;
  assign signed_overflow = c_msb_in ^ c_msb_out;
  assign result_msb      = alu_f[fsa_pkg::FSA_MSB];
  // Open drain: pulls low on nonzero, released so slices wire together
  assign zero_detect_o   = 1'b0;
  assign zero_detect_oe  = |alu_f;
  // Lookahead terms valid in arithmetic functions only
  assign carry_generate_n  = ~(arith & (gen[3] | (prop[3] & gen[2]) |
                               (prop[3] & prop[2] & gen[1]) |
                               (prop[3] & prop[2] & prop[1] & gen[0])));
  assign carry_propagate_n = ~(arith & (&prop));

  // Shift pins: up drives MSB end, down drives LSB end
  assign stack_msb_shift_pin_o  = alu_f[fsa_pkg::FSA_MSB];
  assign stack_msb_shift_pin_oe = (dest == fsa_pkg::FSA_DST_RQU) ||
                                  (dest == fsa_pkg::FSA_DST_RU);
  assign acc_msb_shift_pin_o    = state_q.acc[fsa_pkg::FSA_MSB];
  assign acc_msb_shift_pin_oe   = (dest == fsa_pkg::FSA_DST_RQU) ||
                                  (dest == fsa_pkg::FSA_DST_RU);
  assign stack_lsb_shift_pin_o  = alu_f[0];
  assign stack_lsb_shift_pin_oe = (dest == fsa_pkg::FSA_DST_RQD) ||
                                  (dest == fsa_pkg::FSA_DST_RD);
  assign acc_lsb_shift_pin_o    = state_q.acc[0];
  assign acc_lsb_shift_pin_oe   = (dest == fsa_pkg::FSA_DST_RQD) ||
                                  (dest == fsa_pkg::FSA_DST_RD);

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_same_port_read: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (first_read_select == write_port_select) |-> (port_a == port_b))
    else $error("ports differ on equal addresses");

  a_acc_load_edge: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dest == fsa_pkg::FSA_DST_QREG) |=> (state_q.acc == $past(alu_f)))
    else $error("working register missed its load");

  a_acc_hold_nop: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dest == fsa_pkg::FSA_DST_NOP || dest == fsa_pkg::FSA_DST_RD ||
     dest == fsa_pkg::FSA_DST_RU) |=> $stable(state_q.acc))
    else $error("working register changed without a load");

  a_stack_write_b: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dest == fsa_pkg::FSA_DST_RAMF) |=>
      (state_q.stack[$past(write_port_select)] == $past(alu_f)))
    else $error("stack word missed its write");

  a_port_a_untouched: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (first_read_select != write_port_select) |=>
      (state_q.stack[$past(first_read_select)] ==
       $past(state_q.stack[first_read_select])))
    else $error("write reached the first-port word");

  a_down_shift_in: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dest == fsa_pkg::FSA_DST_RQD) |=>
      (state_q.stack[$past(write_port_select)][3] == $past(stack_msb_shift_pin_i)) &&
      (state_q.acc[3] == $past(acc_msb_shift_pin_i)) &&
      (state_q.acc[2:0] == $past(state_q.acc[3:1])))
    else $error("down shift took wrong bits");

  a_up_shift_pins: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dest == fsa_pkg::FSA_DST_RQU) |-> stack_msb_shift_pin_oe && !stack_lsb_shift_pin_oe &&
      (stack_msb_shift_pin_o == alu_f[3]) ##1
      (state_q.stack[$past(write_port_select)][0] == $past(stack_lsb_shift_pin_i)))
    else $error("up shift pin use wrong");

  a_idle_pins_off: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (dest[2] == 1'b0) |-> !(stack_msb_shift_pin_oe || stack_lsb_shift_pin_oe ||
                            acc_msb_shift_pin_oe || acc_lsb_shift_pin_oe))
    else $error("shift pin driven without a shift");

  a_out_source_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (output_enable_n |-> !slice_output_oe) and
    ((dest == fsa_pkg::FSA_DST_RAMA) |-> (slice_output_o == port_a)))
    else $error("slice output source or enable wrong");

  a_add_overflow: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (func == fsa_pkg::FSA_FN_ADD) |->
      (signed_overflow == ((op_r[3] == op_s[3]) && (alu_f[3] != op_r[3]))))
    else $error("overflow flag wrong on add");

  a_zero_release: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (alu_f == fsa_pkg::FSA_ZERO) == !zero_detect_oe)
    else $error("zero detect wrong");

  a_zero_operand: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (src == fsa_pkg::FSA_SRC_DZ && func == fsa_pkg::FSA_FN_OR) |->
      (alu_f == direct_input))
    else $error("inhibited operand not zero");

  // Carry out is generate, or propagate with the incoming carry
  a_carry_chain: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (func == fsa_pkg::FSA_FN_ADD) |->
      (carry_out == (!carry_generate_n || (!carry_propagate_n && carry_in))))
    else $error("lookahead terms disagree with carry out");

endmodule

//--- verification/fsa_nbr_model.sv
// Neighbour slices seen from the four shift pins of one slice.
// Assumes the neighbours share the clock and the destination field.
module fsa_nbr_model (
  input  wire logic       sys_clk,  // Shared slice clock
  input  wire logic [2:0] dest,     // Destination field
  input  wire logic [3:0] slice_o,  // Slice pin values
  input  wire logic [3:0] slice_oe, // Slice pin drives
  input  wire logic [3:0] nb_val,   // Neighbour pin values
  output logic      [3:0] pin_lvl   // Resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pin order: stack msb, stack lsb, acc msb, acc lsb
  logic [3:0] nb_oe;
  logic [3:0] last_q = 4'h0;
  assign nb_oe = {dest == 3'h6, dest == 3'h4, dest >= 3'h6, dest == 3'h4 || dest == 3'h5};
  always @(posedge sys_clk) last_q <= pin_lvl;
  // Undriven pins flip so a stale value never reads as valid
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_lvl[i] = slice_oe[i] ? slice_o[i] : (nb_oe[i] ? nb_val[i] : ~last_q[i]);
    end
  end
endmodule

//--- verification/fsa_slice_tb.sv
// Self-checking bench for the four-bit slice with its stack mirrored here.
// Assumes one clock; inputs change on the falling edge.
module fsa_slice_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 0;
  logic       sys_rst = 1;
  // Writes word 0 during reset so the first checked edges see known data
  logic [8:0] mw = 9'h0df;
  logic [3:0] ra = 4'h0, rb = 4'h0, dd = 4'h0, nbv = 4'h0;
  logic       ci = 0, oen = 0;
  wire  [3:0] y, po, poe, pl;
  wire        yoe, co, ov, gn, pn, f3, zo, zoe;
  logic [3:0] stk [16];
  logic [3:0] acc;
  int         err_total, checks;
  always #12.5 sys_clk = ~sys_clk;
  fsa_slice u_fsa_slice (.sys_clk(sys_clk), .sys_rst(sys_rst), .microcode_word(mw),
    .first_read_select(ra), .write_port_select(rb), .direct_input(dd), .carry_in(ci),
    .output_enable_n(oen), .slice_output_o(y), .slice_output_oe(yoe), .carry_out(co),
    .signed_overflow(ov), .carry_generate_n(gn), .carry_propagate_n(pn), .result_msb(f3),
    .zero_detect_o(zo), .zero_detect_oe(zoe),
    .stack_msb_shift_pin_i(pl[0]), .stack_msb_shift_pin_o(po[0]),
    .stack_msb_shift_pin_oe(poe[0]), .stack_lsb_shift_pin_i(pl[1]),
    .stack_lsb_shift_pin_o(po[1]), .stack_lsb_shift_pin_oe(poe[1]),
    .acc_msb_shift_pin_i(pl[2]), .acc_msb_shift_pin_o(po[2]), .acc_msb_shift_pin_oe(poe[2]),
    .acc_lsb_shift_pin_i(pl[3]), .acc_lsb_shift_pin_o(po[3]), .acc_lsb_shift_pin_oe(poe[3]));
  fsa_nbr_model u_fsa_nbr_model (.sys_clk(sys_clk), .dest(mw[8:6]), .slice_o(po),
    .slice_oe(poe), .nb_val(nbv), .pin_lvl(pl));
  //////////////////////////////////////////////////////////////////////////////
  task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One instruction: drive, judge the combinational answer, clock, update mirror
  task automatic op(input logic [2:0] s, f, t, input logic [3:0] a, b, d,
                    input logic c, input logic [3:0] n);
    logic [3:0] r, q, xa, xb, res, pp, gg, pe;
    logic [4:0] sum;
    logic       c3, ar;
    @(negedge sys_clk);
    mw = {t, f, s}; ra = a; rb = b; dd = d; ci = c; nbv = n;
    #2;
    r = (s <= 3'h1) ? stk[a] : (s >= 3'h5 ? d : 4'h0);
    case (s)
      3'h0, 3'h2, 3'h6: q = acc;
      3'h1, 3'h3:       q = stk[b];
      3'h4, 3'h5:       q = stk[a];
      default:          q = 4'h0;
    endcase
    xa = (f == 3'h1) ? ~r : r;
    xb = (f == 3'h2) ? ~q : q;
    sum = xa + xb + c;
    c3 = sum[3] ^ xa[3] ^ xb[3];
    ar = f < 3'h3;
    pp = xa | xb;
    gg = xa & xb;
    case (f)
      3'h3:    res = r | q;
      3'h4:    res = r & q;
      3'h5:    res = ~r & q;
      3'h6:    res = r ^ q;
      3'h7:    res = ~(r ^ q);
      default: res = sum[3:0];
    endcase
    pe = {t == 3'h4 || t == 3'h5, t >= 3'h6, t == 3'h4 || t == 3'h5, t >= 3'h6};
    cmp1(yoe, ~oen);
    if (!oen) cmp4(y, t == 3'h2 ? stk[a] : res);
    cmp1(co, ar & sum[4]);
    cmp1(ov, ar & (sum[4] ^ c3));
    cmp1(pn, ~ar | ~&pp);
    cmp1(gn, ~ar | ~(gg[3] | pp[3] & gg[2] | &pp[3:2] & gg[1] | &pp[3:1] & gg[0]));
    cmp1(zoe, res != 4'h0);
    cmp1(zo, 1'b0);
    cmp1(f3, res[3]);
    cmp4(poe, pe);
    cmp4(po & pe, {acc[0], acc[3], res[0], res[3]} & pe);
    @(posedge sys_clk);
    case (t)
      3'h0: acc = res;
      3'h2, 3'h3: stk[b] = res;
      3'h4: begin
        stk[b] = {n[0], res[3:1]};
        acc = {n[2], acc[3:1]};
      end
      3'h5: stk[b] = {n[0], res[3:1]};
      3'h6: begin
        stk[b] = {res[2:0], n[1]};
        acc = {acc[2:0], n[3]};
      end
      default: if (t == 3'h7) stk[b] = {res[2:0], n[1]};
    endcase
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_load;
    for (int i = 0; i < 16; i++) op(3'h7, 3'h3, 3'h3, 4'h0, i[3:0], i[3:0] ^ 4'ha, 0, 4'h0);
    op(3'h7, 3'h3, 3'h0, 4'h0, 4'h0, 4'h6, 0, 4'h0);
  endtask
  task automatic t_alu;
    for (int s = 0; s < 8; s++)
      for (int f = 0; f < 8; f++) op(s[2:0], f[2:0], 3'h1, 4'h3, 4'h9, 4'hc, s[0] ^ f[0], 4'h0);
    op(3'h5, 3'h0, 3'h1, 4'hd, 4'h0, 4'h7, 1, 4'h0);
    op(3'h5, 3'h0, 3'h1, 4'h5, 4'h0, 4'hf, 1, 4'h0);
  endtask
  task automatic t_dest;
    for (int t = 0; t < 8; t++) op(3'h1, 3'h0, t[2:0], 4'h0, 4'h4 + t[3:0], 4'h0, 1, ~t[3:0]);
  endtask
  // Same-word read while writing must still show the old word
  task automatic t_read;
    for (int i = 0; i < 16; i++) begin
      op(3'h5, 3'h0, 3'h2, i[3:0], i[3:0], 4'h1, 0, 4'h0);
      op(3'h1, 3'h6, 3'h1, i[3:0], i[3:0], 4'h0, 0, 4'h0);
      op(3'h4, 3'h3, 3'h1, i[3:0], 4'h0, 4'h0, 0, 4'h0);
    end
  endtask
  task automatic t_oe;
    @(negedge sys_clk);
    oen = 1;
    op(3'h7, 3'h3, 3'h1, 4'h0, 4'h0, 4'h9, 0, 4'h0);
    @(negedge sys_clk);
    oen = 0;
  endtask
  initial begin
    repeat (3) @(negedge sys_clk);
    sys_rst = 0;
    t_load();
    t_alu();
    t_dest();
    t_read();
    t_oe();
    stop_test();
  end
  initial begin
    repeat (1000) @(posedge sys_clk);
    err_total++;
    stop_test();
  end
endmodule
